/* bin_obj_cfg.svh */
// Offsets, field positions and timing figures of the binary input objects.
// Assumes a 50 MHz clock and a 32-bit AHB-Lite register port.
`ifndef BIN_OBJ_CFG_SVH
`define BIN_OBJ_CFG_SVH
`define CLK_HZ       50000000
`define MS_PER_S     1000
`define MS_PER_MIN   60000
`define A_CHAN       8'h00
`define A_BLOCK      8'h04
`define A_STAT       8'h08
`define A_OBJ0       8'h10
`define A_OBJ_STEP   8'h10
`define A_V1         8'h04
`define A_V0         8'h08
`define F_TYPE       2:0
`define F_SEND1      3
`define F_SEND0      4
`define F_CYC        6:5
`define F_RESTORE    9:7
`define F_BLKSET     11:10
`define F_BLKCAN     12
`define F_DEB        2:0
`define F_MINUTES    8:3
`define F_POL        9
`define CHAN_RST     10'h00_09
`define PCT_MAX      8'h64
`define RS_MAX_MS    16'h3A_98
`define RS_5S_MS     16'h13_88
`define RS_10S_MS    16'h27_10
`define DEB_MS_0     14'h00_1E
`define DEB_MS_1     14'h00_32
`define DEB_MS_2     14'h00_50
`define DEB_MS_3     14'h00_64
`define DEB_MS_4     14'h00_C8
`define DEB_MS_5     14'h03_E8
`define DEB_MS_6     14'h13_88
`define DEB_MS_7     14'h27_10
`endif

/* bin_obj_pkg.sv */
// Types shared by the binary input object logic.
// Assumes nothing beyond the cfg header.
`default_nettype none
package bin_obj_pkg;
    typedef enum logic [2:0] {
        T_SWITCH = 3'h0,
        T_PRIO   = 3'h1,
        T_VALUE  = 3'h2,
        T_PCT    = 3'h3,
        T_F16    = 3'h4,
        T_F32    = 3'h5
    } obj_type_e;
    typedef enum logic [1:0] {
        K_IN1 = 2'h0,
        K_IN0 = 2'h1,
        K_UPD = 2'h2
    } kind_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_BUSY = 2'h2
    } tx_state_e;
    typedef struct packed {
        logic [1:0]  obj;
        obj_type_e   typ;
        logic [31:0] value;
    } tx_req_s;
endpackage : bin_obj_pkg
`default_nettype wire

/* bin_obj.sv */
// One binary input channel with three telegram objects, AHB-Lite config.
// Assumes input pins are asynchronous; the transmitter holds tx_ready.
`timescale 1ns/100ps
`include "bin_obj_cfg.svh"
`default_nettype none
module bin_obj #(
    parameter int MS_CYC   = `CLK_HZ / `MS_PER_S,
    parameter int MIN_MS   = `MS_PER_MIN
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               input_pin,
    input  wire logic               bus_ok_pin,
    output logic                    tx_valid,
    output bin_obj_pkg::tx_req_s    tx_req,
    input  wire logic               tx_ready
);
    logic        rs1_reg, rs2_reg;
    logic        rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    assign rst_n = rs2_reg;

    // Bus slave: zero wait, always OKAY
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] rd_next;
    logic [9:0]  chan_reg, chan_next;
    logic        blk_raw_reg, blk_raw_next;
    logic [12:0] ocfg_reg [3];
    logic [12:0] ocfg_next [3];
    logic [31:0] v1_reg [3];
    logic [31:0] v1_next [3];
    logic [31:0] v0_reg [3];
    logic [31:0] v0_next [3];
    logic [2:0]  sw_reg, sw_next;
    logic        level_reg;
    logic        blocked;
    logic        addr_ph;
    assign addr_ph = hsel && htrans[1] && hready;

    function automatic logic [7:0] oaddr(input int i, input logic [7:0] off);
        oaddr = 8'(`A_OBJ0 + i * `A_OBJ_STEP) + off;
    endfunction : oaddr

    always_comb begin
        wr_pend_next = addr_ph && hwrite;
        wr_addr_next = addr_ph ? haddr[7:0] : wr_addr_reg;
        chan_next    = chan_reg;
        blk_raw_next = blk_raw_reg;
        rd_next      = 32'h0000_0000;
        ocfg_next    = ocfg_reg;
        v1_next      = v1_reg;
        v0_next      = v0_reg;
        if (wr_pend_reg) begin
            if (wr_addr_reg == `A_CHAN) chan_next = hwdata[9:0];
            if (wr_addr_reg == `A_BLOCK) blk_raw_next = hwdata[0];
            for (int i = 0; i < 3; i++) begin
                if (wr_addr_reg == oaddr(i, 8'h00)) ocfg_next[i] = hwdata[12:0];
                if (wr_addr_reg == oaddr(i, `A_V1)) v1_next[i] = hwdata;
                if (wr_addr_reg == oaddr(i, `A_V0)) v0_next[i] = hwdata;
            end
        end
        if (addr_ph && !hwrite) begin
            if (haddr[7:0] == `A_CHAN) rd_next = {22'h0, chan_reg};
            if (haddr[7:0] == `A_BLOCK) rd_next = {31'h0, blk_raw_reg};
            if (haddr[7:0] == `A_STAT) rd_next = {27'h0, sw_reg, blocked, level_reg};
            for (int i = 0; i < 3; i++) begin
                if (haddr[7:0] == oaddr(i, 8'h00)) rd_next = {19'h0, ocfg_reg[i]};
                if (haddr[7:0] == oaddr(i, `A_V1)) rd_next = v1_reg[i];
                if (haddr[7:0] == oaddr(i, `A_V0)) rd_next = v0_reg[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            chan_reg    <= `CHAN_RST;
            blk_raw_reg <= 1'b0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                ocfg_reg[i] <= 13'h0000;
                v1_reg[i]   <= 32'h0000_0000;
                v0_reg[i]   <= 32'h0000_0000;
            end
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            chan_reg    <= chan_next;
            blk_raw_reg <= blk_raw_next;
            hrdata      <= rd_next;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            ocfg_reg    <= ocfg_next;
            v1_reg      <= v1_next;
            v0_reg      <= v0_next;
        end
    end

    // Pins, millisecond and minute ticks, debounce, restore timer
    logic        in1_reg, in2_reg, ok1_reg, ok2_reg, ok3_reg;
    logic [15:0] ms_div_reg, ms_div_next;
    logic        ms_tick;
    logic [15:0] min_div_reg, min_div_next;
    logic [5:0]  min_cnt_reg, min_cnt_next;
    logic        cyc_tick;
    logic [13:0] deb_reg, deb_next;
    logic        level_next;
    logic [13:0] deb_ms;
    logic [15:0] rs_ms_reg, rs_ms_next;
    logic        restart;
    logic        blk_q_reg;
    assign ms_tick = (ms_div_reg == 16'(MS_CYC - 1));
    assign restart = ok2_reg && !ok3_reg;
    assign blocked = blk_raw_reg ^ chan_reg[`F_POL];

    always_comb begin
        case (chan_reg[`F_DEB])
            3'h0:    deb_ms = `DEB_MS_0;
            3'h1:    deb_ms = `DEB_MS_1;
            3'h2:    deb_ms = `DEB_MS_2;
            3'h3:    deb_ms = `DEB_MS_3;
            3'h4:    deb_ms = `DEB_MS_4;
            3'h5:    deb_ms = `DEB_MS_5;
            3'h6:    deb_ms = `DEB_MS_6;
            default: deb_ms = `DEB_MS_7;
        endcase
        ms_div_next  = ms_tick ? 16'h0000 : ms_div_reg + 16'h0001;
        min_div_next = min_div_reg;
        min_cnt_next = min_cnt_reg;
        cyc_tick     = 1'b0;
        if (ms_tick) begin
            min_div_next = min_div_reg + 16'h0001;
            if (min_div_reg == 16'(MIN_MS - 1)) begin
                min_div_next = 16'h0000;
                min_cnt_next = min_cnt_reg + 6'h01;
                if (min_cnt_reg + 6'h01 >= chan_reg[`F_MINUTES]) begin
                    min_cnt_next = 6'h00;
                    cyc_tick     = 1'b1;
                end
            end
        end
        level_next = level_reg;
        deb_next   = deb_reg;
        if (in2_reg == level_reg) begin
            deb_next = 14'h0000;
        end else if (ms_tick) begin
            deb_next = deb_reg + 14'h0001;
            if (deb_reg + 14'h0001 >= deb_ms) begin
                level_next = in2_reg;
                deb_next   = 14'h0000;
            end
        end
        rs_ms_next = rs_ms_reg;
        if (restart) rs_ms_next = 16'h0000;
        else if (ms_tick && rs_ms_reg < `RS_MAX_MS) rs_ms_next = rs_ms_reg + 16'h0001;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in1_reg     <= 1'b0;
            in2_reg     <= 1'b0;
            ok1_reg     <= 1'b0;
            ok2_reg     <= 1'b0;
            ok3_reg     <= 1'b0;
            ms_div_reg  <= 16'h0000;
            min_div_reg <= 16'h0000;
            min_cnt_reg <= 6'h00;
            deb_reg     <= 14'h0000;
            level_reg   <= 1'b0;
            rs_ms_reg   <= `RS_MAX_MS;
            blk_q_reg   <= 1'b0;
        end else begin
            in1_reg     <= input_pin;
            in2_reg     <= in1_reg;
            ok1_reg     <= bus_ok_pin;
            ok2_reg     <= ok1_reg;
            ok3_reg     <= ok2_reg;
            ms_div_reg  <= ms_div_next;
            min_div_reg <= min_div_next;
            min_cnt_reg <= min_cnt_next;
            deb_reg     <= deb_next;
            level_reg   <= level_next;
            rs_ms_reg   <= rs_ms_next;
            blk_q_reg   <= blocked;
        end
    end

    // Object events and pending telegrams
    logic       rise, fall, blk_set, blk_can;
    logic [2:0] pend_reg, pend_next, ev;
    bin_obj_pkg::kind_e kind_reg [3];
    bin_obj_pkg::kind_e kind_next [3];
    bin_obj_pkg::kind_e ev_kind [3];
    bin_obj_pkg::tx_state_e st_reg, st_next;
    bin_obj_pkg::tx_req_s req_next;
    logic       valid_next;
    logic [1:0] sel;
    assign rise    = level_next && !level_reg;
    assign fall    = !level_next && level_reg;
    assign blk_set = blocked && !blk_q_reg;
    assign blk_can = !blocked && blk_q_reg;

    function automatic logic [15:0] rs_dly(input logic [2:0] m);
        case (m)
            3'h2:    rs_dly = `RS_5S_MS;
            3'h3:    rs_dly = `RS_10S_MS;
            default: rs_dly = `RS_MAX_MS;
        endcase
    endfunction : rs_dly

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic ign, blk, c1, c0, cyc, rs;
            ign = ocfg_reg[i][`F_BLKSET] == 2'h0;
            blk = blocked && !ign;
            c1  = rise && ocfg_reg[i][`F_SEND1] && !blk;
            c0  = fall && ocfg_reg[i][`F_SEND0] && !blk;
            case (ocfg_reg[i][`F_CYC])
                2'h1:    cyc = cyc_tick && !blocked;
                2'h2:    cyc = cyc_tick && !blocked && level_reg;
                2'h3:    cyc = cyc_tick && !blocked && !level_reg;
                default: cyc = 1'b0;
            endcase
            rs  = (restart && ocfg_reg[i][`F_RESTORE] == 3'h1)
                || (ms_tick && ocfg_reg[i][`F_RESTORE] >= 3'h2
                && rs_ms_reg + 16'h0001 == rs_dly(ocfg_reg[i][`F_RESTORE]));
            ev[i]      = 1'b1;
            ev_kind[i] = bin_obj_pkg::K_UPD;
            if (c1 || (blk_set && ocfg_reg[i][`F_BLKSET] == 2'h2)) ev_kind[i] = bin_obj_pkg::K_IN1;
            else if (c0 || (blk_set && ocfg_reg[i][`F_BLKSET] == 2'h3))
                ev_kind[i] = bin_obj_pkg::K_IN0;
            else if (!(cyc || rs || (blk_can && !ign && ocfg_reg[i][`F_BLKCAN]))) ev[i] = 1'b0;
        end
    end

    function automatic logic [31:0] payload(input logic [12:0] cfg, input logic [31:0] v,
                                            input bin_obj_pkg::kind_e k, input logic s);
        payload = 32'h0000_0000;
        case (bin_obj_pkg::obj_type_e'(cfg[`F_TYPE]))
            // on, off, toggle; update repeats state
            bin_obj_pkg::T_SWITCH: payload[0] = (k == bin_obj_pkg::K_UPD) ? s
                                   : (v[1:0] == 2'h2) ? !s : v[0];
            // inactive 00, on 11, off 10
            bin_obj_pkg::T_PRIO: payload[1:0] = (v[1:0] == 2'h1) ? 2'b11
                                   : (v[1:0] == 2'h2) ? 2'b10 : 2'b00;
            bin_obj_pkg::T_VALUE: payload[7:0] = v[7:0];
            bin_obj_pkg::T_PCT: payload[7:0] = (v[7:0] > `PCT_MAX) ? `PCT_MAX : v[7:0];
            bin_obj_pkg::T_F16: payload[15:0] = v[15:0];
            default: payload = v;
        endcase
    endfunction : payload

    always_comb begin
        sel = pend_reg[0] ? 2'h0 : pend_reg[1] ? 2'h1 : 2'h2;
        st_next    = st_reg;
        valid_next = tx_valid;
        req_next   = tx_req;
        pend_next  = pend_reg;
        kind_next  = kind_reg;
        sw_next    = sw_reg;
        case (st_reg)
            bin_obj_pkg::TX_IDLE: begin
                if (pend_reg != 3'h0) begin
                    logic k1;
                    bin_obj_pkg::kind_e k;
                    k  = kind_reg[sel];
                    k1 = (k == bin_obj_pkg::K_IN1)
                        || (k == bin_obj_pkg::K_UPD && level_reg);
                    req_next.obj   = sel;
                    req_next.typ   = bin_obj_pkg::obj_type_e'(ocfg_reg[sel][`F_TYPE]);
                    req_next.value = payload(ocfg_reg[sel], k1 ? v1_reg[sel] : v0_reg[sel],
                                             k, sw_reg[sel]);
                    if (ocfg_reg[sel][`F_TYPE] == 3'h0) sw_next[sel] = req_next.value[0];
                    pend_next[sel] = 1'b0;
                    valid_next     = 1'b1;
                    st_next        = bin_obj_pkg::TX_BUSY;
                end
            end
            bin_obj_pkg::TX_BUSY: begin
                if (tx_ready) begin
                    valid_next = 1'b0;
                    st_next    = bin_obj_pkg::TX_IDLE;
                end
            end
            default: begin
                valid_next = 1'b0;
                st_next    = bin_obj_pkg::TX_IDLE;
            end
        endcase
        // New events win over the take-up clear
        for (int i = 0; i < 3; i++) begin
            if (ev[i]) begin
                pend_next[i] = 1'b1;
                kind_next[i] = ev_kind[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg   <= bin_obj_pkg::TX_IDLE;
            tx_valid <= 1'b0;
            tx_req   <= '0;
            pend_reg <= 3'h0;
            sw_reg   <= 3'h0;
            for (int i = 0; i < 3; i++) kind_reg[i] <= bin_obj_pkg::K_UPD;
        end else begin
            st_reg   <= st_next;
            tx_valid <= valid_next;
            tx_req   <= req_next;
            pend_reg <= pend_next;
            sw_reg   <= sw_next;
            kind_reg <= kind_next;
        end
    end

    sequence s_offer;
        tx_valid && !tx_ready;
    endsequence
    property p_hold;
        @(posedge clk) disable iff (!rst_n) s_offer |=> tx_valid && $stable(tx_req);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped before accept");
    property p_prio;
        @(posedge clk) disable iff (!rst_n)
            tx_valid && tx_req.typ == bin_obj_pkg::T_PRIO |-> tx_req.value[1:0] != 2'b01;
    endproperty
    a_prio: assert property (p_prio) else $error("bad priority code");
    property p_pct;
        @(posedge clk) disable iff (!rst_n)
            tx_valid && tx_req.typ == bin_obj_pkg::T_PCT
            |-> tx_req.value <= {24'h00_0000, `PCT_MAX};
    endproperty
    a_pct: assert property (p_pct) else $error("percentage above 100");
    property p_nocyc;
        @(posedge clk) disable iff (!rst_n)
            blocked && cyc_tick && !rise && !fall && !restart && !blk_set
            && ocfg_reg[0][`F_CYC] == 2'h1 && ocfg_reg[0][`F_RESTORE] == 3'h0
            && !pend_reg[0] |=> !pend_reg[0];
    endproperty
    a_nocyc: assert property (p_nocyc) else $error("cyclic send while blocked");
    property p_rise;
        @(posedge clk) disable iff (!rst_n)
            rise && ocfg_reg[0][`F_SEND1] && !blocked |=> pend_reg[0] || st_reg == bin_obj_pkg::TX_BUSY;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not queued");
    property p_deb;
        @(posedge clk) disable iff (!rst_n) $changed(level_reg) |-> $past(ms_tick);
    endproperty
    a_deb: assert property (p_deb) else $error("level changed off a tick");
    property p_bus;
        @(posedge clk) disable iff (!rst_n) hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus slave not ready or error");
    property p_rs;
        @(posedge clk) disable iff (!rst_n)
            restart && ocfg_reg[0][`F_RESTORE] == 3'h1 |=> pend_reg[0];
    endproperty
    a_rs: assert property (p_rs) else $error("restore update missing");
    property p_tog;
        @(posedge clk) disable iff (!rst_n)
            $rose(tx_valid) && tx_req.typ == bin_obj_pkg::T_SWITCH
            |-> tx_req.value[0] == sw_reg[tx_req.obj];
    endproperty
    a_tog: assert property (p_tog) else $error("switch state not tracked");
endmodule : bin_obj
`default_nettype wire

/* tx_sink.sv */
// Transmit partner: accepts telegrams after a set stall and logs them.
// Assumes the block holds each request until tx_ready is seen high.
`timescale 1ns/100ps
`default_nettype none
module tx_sink (
    input  wire logic                 clk,
    input  wire logic                 tx_valid,
    input  wire bin_obj_pkg::tx_req_s tx_req,
    input  wire logic [3:0]           stall,
    output var  logic                 tx_ready
);
    bin_obj_pkg::tx_req_s q[$];
    logic [3:0]           cnt = 4'h0;
    initial tx_ready = 1'b0;
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            q.push_back(tx_req);
            tx_ready <= 1'b0;
            cnt      <= 4'h0;
        end else if (tx_valid) begin
            cnt      <= cnt + 4'h1;
            tx_ready <= (cnt >= stall);
        end
    end
endmodule : tx_sink
`default_nettype wire

/* bin_obj_test.sv */
// Self-checking bench for one binary input channel with three objects.
// Assumes the tx_sink partner logs every accepted telegram.
`timescale 1ns/100ps
`include "bin_obj_cfg.svh"
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module bin_obj_test;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = 32'h0000_0000;
    logic [1:0]           htrans = 2'h0;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = 32'h0000_0000;
    logic                 input_pin = 1'b0;
    logic                 bus_ok_pin = 1'b1;
    logic [3:0]           stall = 4'h0;
    logic                 hrdy, hresp, tx_valid, tx_ready;
    logic [31:0]          hrdata, rd;
    bin_obj_pkg::tx_req_s tx_req;
    int                   fail_count = 0;
    int                   total_checks = 0;
    logic [31:0] v1t [6] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_00FF,
                             32'h0000_00C8, 32'h0000_7BFF, 32'h3F80_0000};
    logic [31:0] v0t [6] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0000,
                             32'h0000_0064, 32'h0000_FBFF, 32'hC000_0000};
    logic [31:0] e1t [6] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_00FF,
                             32'h0000_0064, 32'h0000_7BFF, 32'h3F80_0000};

    always #10 clk = ~clk;

    bin_obj #(.MS_CYC(5), .MIN_MS(3)) dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .input_pin(input_pin),
        .bus_ok_pin(bus_ok_pin), .tx_valid(tx_valid), .tx_req(tx_req),
        .tx_ready(tx_ready));
    tx_sink sink (.clk(clk), .tx_valid(tx_valid), .tx_req(tx_req), .stall(stall),
        .tx_ready(tx_ready));

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : bus

    function automatic logic [31:0] cw(input int t, input int s, input int cy, input int rs,
        input int bs, input int cn);
        return {19'h0, 1'(cn), 2'(bs), 3'(rs), 2'(cy), 2'(s), 3'(t)};
    endfunction : cw

    task automatic obj(input int i, input logic [31:0] c, input logic [31:0] v1,
        input logic [31:0] v0);
        bus(1'b1, 32'h10 + 32'h10 * i, c);
        bus(1'b1, 32'h14 + 32'h10 * i, v1);
        bus(1'b1, 32'h18 + 32'h10 * i, v0);
    endtask : obj

    task automatic pin(input logic v);
        @(posedge clk);
        input_pin <= v;
    endtask : pin

    task automatic exp_tx(input int o, input int t, input logic [31:0] v);
        bin_obj_pkg::tx_req_s r;
        int                   n;
        n = 0;
        while (sink.q.size() == 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (sink.q.size() != 0) r = sink.q.pop_front();
        `CHK({r.obj, r.typ, r.value}, {2'(o), 3'(t), v})
    endtask : exp_tx

    task automatic none(input int c);
        repeat (c) @(posedge clk);
        `CHK(sink.q.size(), 0)
    endtask : none

    // Drops cyclic telegrams already under way
    task automatic flush();
        repeat (40) @(posedge clk);
        sink.q.delete();
    endtask : flush

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 32'h0000_0000, 32'h0000_0000); `CHK(rd, {22'h0, `CHAN_RST})
        bus(1'b0, 32'h0000_0014, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
        bus(1'b0, 32'h0000_0040, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
        bus(1'b1, 32'h0000_0000, 32'h0000_0000);
        // Two passes cover all six types, second with a slow transmitter
        for (int j = 0; j < 2; j++) begin
            stall <= 4'(j * 6);
            for (int i = 0; i < 3; i++) obj(i, cw(3'(3*j+i), 2'h3, 0, 0, 0, 0),
                v1t[3*j+i], v0t[3*j+i]);
            pin(1'b1);
            for (int i = 0; i < 3; i++) exp_tx(i, 3*j+i, e1t[3*j+i]);
            pin(1'b0);
            for (int i = 0; i < 3; i++) exp_tx(i, 3*j+i, v0t[3*j+i]);
        end
        obj(1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        obj(2, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        obj(0, cw(0, 3, 0, 0, 0, 0), 32'h0000_0001, 32'h0000_0002);
        pin(1'b1); exp_tx(0, 0, 32'h0000_0001); // on
        pin(1'b0); exp_tx(0, 0, 32'h0000_0000); // toggle
        obj(0, cw(0, 3, 0, 0, 0, 0), 32'h0000_0002, 32'h0000_0002);
        pin(1'b1); exp_tx(0, 0, 32'h0000_0001); // toggle
        pin(1'b0);
        repeat (50) @(posedge clk);
        pin(1'b1); none(300); // short glitch
        obj(0, cw(0, 3, 0, 0, 2, 0), 32'h0000_0001, 32'h0000_0000);
        obj(1, cw(2, 3, 0, 0, 3, 1), 32'h0000_0011, 32'h0000_0022);
        obj(2, cw(2, 3, 0, 0, 0, 0), 32'h0000_0033, 32'h0000_0044);
        bus(1'b1, 32'h0000_0004, 32'h0000_0001);
        exp_tx(0, 0, 32'h0000_0001); // as rising
        exp_tx(1, 2, 32'h0000_0022); // as falling
        none(300);
        pin(1'b0); exp_tx(2, 2, 32'h0000_0044); // ignore
        none(300); // others held
        bus(1'b1, 32'h0000_0004, 32'h0000_0000); exp_tx(1, 2, 32'h0000_0022);
        none(300); // no update
        bus(1'b1, 32'h0000_0000, 32'h0000_0008);
        obj(1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        obj(2, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        obj(0, cw(2, 0, 1, 0, 1, 0), 32'h0000_0066, 32'h0000_0077);
        flush(); exp_tx(0, 2, 32'h0000_0077); // always
        bus(1'b1, 32'h0000_0004, 32'h0000_0001); flush(); none(100);
        bus(1'b1, 32'h0000_0004, 32'h0000_0000); exp_tx(0, 2, 32'h0000_0077);
        obj(0, cw(2, 0, 2, 0, 1, 0), 32'h0000_0066, 32'h0000_0077);
        flush(); none(100); // only on 1
        obj(0, cw(2, 0, 3, 0, 1, 0), 32'h0000_0066, 32'h0000_0077);
        flush(); exp_tx(0, 2, 32'h0000_0077); // only on 0
        obj(0, cw(2, 0, 0, 1, 0, 0), 32'h0000_0066, 32'h0000_0077);
        obj(1, cw(2, 0, 0, 2, 0, 0), 32'h0000_0088, 32'h0000_0099);
        flush();
        @(posedge clk) bus_ok_pin <= 1'b0;
        repeat (10) @(posedge clk);
        bus_ok_pin <= 1'b1;
        exp_tx(0, 2, 32'h0000_0077); // now
        none(24700); // not early
        exp_tx(1, 2, 32'h0000_0099); // after 5 s
        bus(1'b1, 32'h0000_0000, 32'h0000_0200);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000); `CHK(rd[1], 1'b1)
        bus(1'b1, 32'h0000_0004, 32'h0000_0001);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000); `CHK(rd[1], 1'b0)
        close_out();
    end

    // Whole run is about 28000 cycles
    initial begin
        #(90000 * 20);
        fail_count++;
        close_out();
    end
endmodule : bin_obj_test
`default_nettype wire
